// *** rtl/write_image_cmd_cfg.svh ***
// offsets, codes and timing counts of the programmer sequencer
`ifndef WRITE_IMAGE_CMD_CFG_SVH
`define WRITE_IMAGE_CMD_CFG_SVH
`define CLK_HZ 20000000
`define BAUD_RATE 9600
`define BAUD_DIV (`CLK_HZ / `BAUD_RATE)
`define ERASE_WAIT_MS 100
`define ERASE_WAIT_CYC (`ERASE_WAIT_MS * (`CLK_HZ / 1000))
`define TGT_RST_CYC 32'd16
`define ROUTINE_LEN 16'd64
`define ROUTINE_BASE 16'h0000
`define BLOCK_LEN 3'd5
`define BURST_LEN 3'd3
`define FILL_BYTE 8'hff
`define CODE_ERASE 8'h01
`define CODE_WRITE 8'h02
`define FRAME_BITS 4'd10
`define TXD_IDLE 1'b1
`endif

// *** rtl/write_image_cmd_pkg.sv ***
// types shared by the programmer sequencer
package write_image_cmd_pkg;
    typedef enum logic [2:0] {
        erase_cmd = 3'b000,
        blank_test_cmd = 3'b001,
        copy_cmd = 3'b010,
        write_image_cmd = 3'b011,
        compare_image_cmd = 3'b100
    } op_e;
    typedef enum logic [3:0] {
        st_idle = 4'b0000,
        st_rst = 4'b0001,
        st_ewait = 4'b0010,
        st_loc = 4'b0011,
        st_fwait = 4'b0100,
        st_fcap = 4'b0101,
        st_frame = 4'b0110,
        st_tx = 4'b0111,
        st_rx = 4'b1000,
        st_after = 4'b1001,
        st_done = 4'b1010
    } st_e;
    typedef enum logic [1:0] {
        ph_routine = 2'b00,
        ph_block = 2'b01,
        ph_loc = 2'b10
    } ph_e;
    typedef struct packed {
        op_e op;
        logic burst_variant;
        logic otp_target;
        logic [15:0] start_addr;
        logic [15:0] end_addr;
    } req_s;
    typedef struct packed {
        logic rd;
        logic wr;
        logic monitor_space;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_s;
    typedef struct packed {
        st_e st;
        ph_e ph;
        req_s req;
        logic [15:0] addr;
        logic [15:0] rcnt;
        logic [4:0][7:0] frame;
        logic [2:0] flen;
        logic [2:0] fidx;
        logic [1:0] rx_need;
        logic echo;
        logic [7:0] mem_byte;
        logic [31:0] wait_cnt;
        logic [15:0] tbaud;
        logic [3:0] tbit;
        logic [9:0] tsh;
        logic txd;
        logic [1:0] rsync;
        logic rbusy;
        logic [15:0] rbaud;
        logic [3:0] rbit;
        logic [7:0] rsh;
        logic rx_valid;
        logic [7:0] rx_byte;
        mem_s mem;
        logic tgt_rst_n;
        logic erase_mode;
        logic busy;
        logic done;
        logic err;
        logic refused;
    } seq_s;
endpackage

// *** rtl/pair_buffer.sv ***
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
    parameter int W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    typedef struct packed {
        logic [1:0][W-1:0] d;
        logic [1:0] cnt;
    } buf_s;
    buf_s s;
    buf_s n;
    logic push;
    logic pop;
    assign in_ready_o = s.cnt != 2'd2;
    assign out_valid_o = s.cnt != 2'd0;
    assign out_data_o = s.d[0];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_comb begin
        n = s;
        if (pop) begin
            n.d[0] = s.d[1];
            n.cnt = n.cnt - 2'd1;
        end
        if (push) begin
            n.d[(s.cnt == 2'd1) && !pop] = in_data_i;
            n.cnt = n.cnt + 2'd1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule
`default_nettype wire

// *** rtl/write_image_cmd_seq.sv ***
// programmer sequencer driving a target's bootstrap loader over serial
// Function
// (RULE_01) write command sends user-map image bytes to the target.
// (RULE_02) copy command writes the target's returned bytes into the user map.
// (RULE_03) first variant downloads the programming routine before an erase or write command.
// (RULE_04) target runs the downloaded routine from its first RAM location.
// (RULE_05) command block: start address, end address, then one command byte.
// (RULE_06) target returns to its loader after erase or write finishes.
// (RULE_07) blank test, copy and compare use dump mode, no routine.
// (RULE_08) second variant sends bursts: address high, address low, data.
// (RULE_09) burst data byte is all ones except when writing.
// (RULE_10) target answers each burst with one address byte, checked here.
// (RULE_11) second variant erase: erase mode, release reset, wait 100 ms.
// (RULE_12) erase refused for one-time-programmable targets.
// (RULE_13) next burst waits for the echo; mismatching echo is an error.
// (RULE_14) bytes framed: start bit, eight data bits lsb first, stop bit.
`timescale 1ns/1ps
`default_nettype none
`include "write_image_cmd_cfg.svh"
module write_image_cmd_seq import write_image_cmd_pkg::*; #(
    parameter logic [15:0] BAUD_DIV = 16'(`BAUD_DIV),
    parameter logic [15:0] ROUTINE_LEN = `ROUTINE_LEN,
    parameter logic [31:0] ERASE_WAIT_CYC = 32'(`ERASE_WAIT_CYC)
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire req_s req_i,
    output var mem_s mem_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic rxd_i,
    output logic txd_o,
    output logic tgt_rst_n_o,
    output logic erase_mode_o,
    output logic busy_o,
    output logic done_o,
    output logic err_o,
    output logic refused_o
);
    seq_s s;
    seq_s n;
    logic tx_load;
    logic tx_idle;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [7:0] buf_out_data;
    logic got;

    function automatic logic is_read(input op_e op);
        is_read = (op == blank_test_cmd) || (op == copy_cmd) || (op == compare_image_cmd);
    endfunction

    pair_buffer #(.W(8)) rx_buf (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(s.rx_valid),
        .in_data_i(s.rx_byte),
        .in_ready_o(buf_in_ready),
        .out_valid_o(buf_out_valid),
        .out_data_o(buf_out_data),
        .out_ready_i(buf_out_ready)
    );

    assign buf_out_ready = (s.st == st_idle) || (s.st == st_rx && s.rx_need != 2'd0);
    assign got = buf_out_valid && s.st == st_rx && s.rx_need != 2'd0;
    assign tx_idle = (s.tbaud == 16'h0000) && (s.tbit == 4'h0);
    assign mem_o = s.mem;
    assign txd_o = s.txd;
    assign tgt_rst_n_o = s.tgt_rst_n;
    assign erase_mode_o = s.erase_mode;
    assign busy_o = s.busy;
    assign done_o = s.done;
    assign err_o = s.err;
    assign refused_o = s.refused;

    always_comb begin
        n = s;
        tx_load = 1'b0;
        n.done = 1'b0;
        n.mem.rd = 1'b0;
        n.mem.wr = 1'b0;
        n.rx_valid = 1'b0;
        // receiver, mid-bit sampling
        n.rsync = {s.rsync[0], rxd_i};
        if (!s.rbusy) begin
            if (!s.rsync[1]) begin
                n.rbusy = 1'b1;
                n.rbaud = (BAUD_DIV >> 1) - 16'h0001;
                n.rbit = 4'h0;
            end
        end else if (s.rbaud != 16'h0000) begin
            n.rbaud = s.rbaud - 16'h0001;
        end else begin
            n.rbaud = BAUD_DIV - 16'h0001;
            if (s.rbit == 4'h0) begin
                if (s.rsync[1]) begin
                    n.rbusy = 1'b0;
                end else begin
                    n.rbit = 4'h1;
                end
            end else if (s.rbit != 4'h9) begin
                n.rsh = {s.rsync[1], s.rsh[7:1]}; // RULE_14
                n.rbit = s.rbit + 4'h1;
            end else begin
                n.rbusy = 1'b0;
                n.rx_valid = s.rsync[1]; // RULE_14
                n.rx_byte = s.rsh;
            end
        end
        if (s.rx_valid && !buf_in_ready) begin
            n.err = 1'b1;
        end
        // transmitter shift
        if (s.tbaud != 16'h0000) begin
            n.tbaud = s.tbaud - 16'h0001;
        end else if (s.tbit != 4'h0) begin
            n.txd = s.tsh[0];
            n.tsh = {1'b1, s.tsh[9:1]};
            n.tbit = s.tbit - 4'h1;
            n.tbaud = BAUD_DIV - 16'h0001;
        end
        case (s.st)
            st_idle: begin
                n.busy = 1'b0;
                if (start_i) begin
                    n.req = req_i;
                    n.busy = 1'b1;
                    n.err = 1'b0;
                    n.refused = 1'b0;
                    n.addr = req_i.start_addr;
                    if (req_i.op == erase_cmd && req_i.otp_target) begin
                        n.refused = 1'b1; // RULE_12
                        n.st = st_done;
                    end else begin
                        n.tgt_rst_n = 1'b0;
                        n.erase_mode = req_i.burst_variant && req_i.op == erase_cmd; // RULE_11
                        n.wait_cnt = `TGT_RST_CYC;
                        n.st = st_rst;
                    end
                end
            end
            st_rst: begin
                if (s.wait_cnt != 32'h0) begin
                    n.wait_cnt = s.wait_cnt - 32'h1;
                end else begin
                    n.tgt_rst_n = 1'b1;
                    if (s.req.burst_variant && s.req.op == erase_cmd) begin
                        n.wait_cnt = ERASE_WAIT_CYC; // RULE_11
                        n.st = st_ewait;
                    end else if (s.req.burst_variant || is_read(s.req.op)) begin
                        n.ph = ph_loc; // RULE_07
                        n.st = st_loc;
                    end else begin
                        n.ph = ph_routine; // RULE_03
                        n.rcnt = 16'h0000;
                        n.st = st_loc;
                    end
                end
            end
            st_ewait: begin
                if (s.wait_cnt != 32'h0) begin
                    n.wait_cnt = s.wait_cnt - 32'h1;
                end else begin
                    n.ph = ph_loc;
                    n.st = st_loc;
                end
            end
            st_loc: begin
                if (s.ph == ph_routine) begin
                    if (s.rcnt == ROUTINE_LEN) begin
                        n.frame[0] = s.req.start_addr[15:8]; // RULE_05
                        n.frame[1] = s.req.start_addr[7:0];
                        n.frame[2] = s.req.end_addr[15:8];
                        n.frame[3] = s.req.end_addr[7:0];
                        n.frame[4] = (s.req.op == erase_cmd) ? `CODE_ERASE : `CODE_WRITE;
                        n.flen = `BLOCK_LEN;
                        n.rx_need = (s.req.op == erase_cmd) ? 2'd1 : 2'd0;
                        n.echo = 1'b0;
                        n.fidx = 3'd0;
                        n.ph = ph_block;
                        n.st = st_tx;
                    end else begin
                        n.mem.rd = 1'b1; // RULE_03
                        n.mem.monitor_space = 1'b1;
                        n.mem.addr = `ROUTINE_BASE + s.rcnt;
                        n.st = st_fwait;
                    end
                end else if (s.req.op == write_image_cmd || s.req.op == compare_image_cmd) begin
                    n.mem.rd = 1'b1; // RULE_01
                    n.mem.monitor_space = 1'b0;
                    n.mem.addr = s.addr;
                    n.st = st_fwait;
                end else begin
                    n.st = st_frame;
                end
            end
            st_fwait: begin
                n.st = st_fcap;
            end
            st_fcap: begin
                n.mem_byte = mem_rdata_i;
                n.st = st_frame;
            end
            st_frame: begin
                n.fidx = 3'd0;
                n.echo = 1'b0;
                n.st = st_tx;
                if (s.ph == ph_routine) begin
                    n.frame[0] = s.mem_byte;
                    n.flen = 3'd1;
                    n.rx_need = 2'd0;
                    n.rcnt = s.rcnt + 16'h0001;
                end else if (s.req.burst_variant) begin
                    n.frame[0] = s.addr[15:8]; // RULE_08
                    n.frame[1] = s.addr[7:0];
                    n.frame[2] = (s.req.op == write_image_cmd) ? s.mem_byte : `FILL_BYTE; // RULE_09
                    n.flen = `BURST_LEN;
                    n.echo = 1'b1; // RULE_13
                    n.rx_need = is_read(s.req.op) ? 2'd2 : 2'd1;
                end else if (s.req.op == write_image_cmd) begin
                    n.frame[0] = s.mem_byte; // RULE_01
                    n.flen = 3'd1;
                    n.rx_need = 2'd0;
                end else begin
                    n.frame[0] = s.addr[15:8]; // RULE_07
                    n.frame[1] = s.addr[7:0];
                    n.flen = 3'd2;
                    n.rx_need = 2'd1;
                end
            end
            st_tx: begin
                if (s.fidx == s.flen) begin
                    n.st = st_rx;
                end else if (tx_idle) begin
                    tx_load = 1'b1;
                    n.tsh = {1'b1, s.frame[s.fidx], 1'b0}; // RULE_14
                    n.tbit = `FRAME_BITS;
                    n.fidx = s.fidx + 3'd1;
                end
            end
            st_rx: begin
                if (s.rx_need == 2'd0) begin
                    n.st = st_after;
                end else if (buf_out_valid) begin
                    n.rx_need = s.rx_need - 2'd1;
                    if (s.echo) begin
                        n.echo = 1'b0;
                        if (buf_out_data != s.addr[7:0]) begin
                            n.err = 1'b1; // RULE_10
                            n.st = st_done;
                        end
                    end else begin
                        case (s.req.op)
                            blank_test_cmd: begin
                                if (buf_out_data != `FILL_BYTE) begin
                                    n.err = 1'b1;
                                end
                            end
                            compare_image_cmd: begin
                                if (buf_out_data != s.mem_byte) begin
                                    n.err = 1'b1;
                                end
                            end
                            copy_cmd: begin
                                n.mem.wr = 1'b1; // RULE_02
                                n.mem.monitor_space = 1'b0;
                                n.mem.addr = s.addr;
                                n.mem.wdata = buf_out_data;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            st_after: begin
                n.st = st_loc;
                if (s.ph == ph_block) begin
                    if (s.req.op == erase_cmd) begin
                        n.st = st_done;
                    end else begin
                        n.ph = ph_loc;
                    end
                end else if (s.ph == ph_loc) begin
                    if (s.req.op == erase_cmd || s.addr == s.req.end_addr) begin
                        n.st = st_done;
                    end else begin
                        n.addr = s.addr + 16'h0001;
                    end
                end
            end
            st_done: begin
                if (tx_idle) begin
                    n.done = 1'b1;
                    n.busy = 1'b0;
                    n.erase_mode = 1'b0;
                    n.st = st_idle;
                end
            end
            default: begin
                n.st = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.txd <= `TXD_IDLE;
            s.rsync <= 2'b11;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_fetch_to_tx;
        s.st == st_frame ##1 s.st == st_tx;
    endsequence
    property p_image_sent;
        (s.st == st_fcap && s.ph == ph_loc && s.req.op == write_image_cmd) |=> s_fetch_to_tx
            and (##1 s.frame[s.req.burst_variant ? 2 : 0] == $past(mem_rdata_i, 2));
    endproperty
    a_image_sent: assert property (p_image_sent) else $error("image byte not sent"); // RULE_01
    property p_copy_store;
        (got && !s.echo && s.req.op == copy_cmd) |=>
            (mem_o.wr && mem_o.wdata == $past(buf_out_data) && mem_o.addr == $past(s.addr));
    endproperty
    a_copy_store: assert property (p_copy_store) else $error("copy byte not stored"); // RULE_02
    property p_routine_first;
        (s.st == st_tx && s.ph == ph_block) |-> (s.rcnt == ROUTINE_LEN && !s.req.burst_variant);
    endproperty
    a_routine_first: assert property (p_routine_first) else $error("block before routine"); // RULE_03
    property p_block_layout;
        (s.st == st_tx && s.ph == ph_block) |-> (s.flen == `BLOCK_LEN
            && s.frame[0] == s.req.start_addr[15:8] && s.frame[3] == s.req.end_addr[7:0]
            && s.frame[4] == ((s.req.op == erase_cmd) ? `CODE_ERASE : `CODE_WRITE));
    endproperty
    a_block_layout: assert property (p_block_layout) else $error("bad command block"); // RULE_05
    property p_dump_mode;
        (s.st == st_rst && s.wait_cnt == 32'h0 && is_read(s.req.op)) |=> s.ph == ph_loc;
    endproperty
    a_dump_mode: assert property (p_dump_mode) else $error("read op used routine"); // RULE_07
    property p_burst_layout;
        (s.st == st_tx && s.ph == ph_loc && s.req.burst_variant) |->
            (s.flen == `BURST_LEN && s.frame[0] == s.addr[15:8] && s.frame[1] == s.addr[7:0]);
    endproperty
    a_burst_layout: assert property (p_burst_layout) else $error("bad burst"); // RULE_08
    sequence s_abort;
        err_o && s.st == st_done ##1 done_o;
    endsequence
    property p_echo_check;
        (got && s.echo && buf_out_data != s.addr[7:0]) |=> s_abort;
    endproperty
    a_echo_check: assert property (p_echo_check) else $error("echo mismatch missed"); // RULE_10
    property p_otp_refuse;
        (s.st == st_idle && start_i && req_i.op == erase_cmd && req_i.otp_target) |=>
            (refused_o && !erase_mode_o && s.st == st_done) ##1 (done_o && tgt_rst_n_o == $past(tgt_rst_n_o, 2));
    endproperty
    a_otp_refuse: assert property (p_otp_refuse) else $error("otp erase not refused"); // RULE_12
    property p_start_bit;
        tx_load |=> ##1 !txd_o ##1 !txd_o;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit missing"); // RULE_14
endmodule
`default_nettype wire

// *** test/target_model.sv ***
// behavioural target running its bootstrap loader, seen over the serial link
`timescale 1ns/1ps
`default_nettype none
module target_model import write_image_cmd_pkg::*; #(
    parameter int BAUD_DIV = 4,
    parameter int ROUTINE_LEN = 2
) (
    input wire logic ref_clk_i,
    input wire logic tgt_rst_n_i,
    input wire logic txd_i,
    input wire logic burst_i,
    input wire op_e op_i,
    input wire logic bad_echo_i,
    output logic rxd_o
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    logic [7:0] lo;
    int cnt;
    // dump contents, all ones only for address low byte c3
    function automatic logic [7:0] dump(logic [7:0] a);
        return a ^ 8'h3c;
    endfunction
    task automatic put(logic [7:0] v);
        @(negedge ref_clk_i);
        rxd_o = 1'b0;
        repeat (BAUD_DIV) @(negedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
            rxd_o = v[i];
            repeat (BAUD_DIV) @(negedge ref_clk_i);
        end
        rxd_o = 1'b1;
        repeat (BAUD_DIV) @(negedge ref_clk_i);
    endtask
    task automatic get(output logic [7:0] v);
        @(negedge txd_i);
        repeat (BAUD_DIV / 2) @(posedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BAUD_DIV) @(posedge ref_clk_i);
            v[i] = txd_i;
        end
        repeat (BAUD_DIV) @(posedge ref_clk_i);
    endtask
    // loader restarts whenever the target is reset
    always @(negedge tgt_rst_n_i) begin
        cnt = 0;
    end
    initial begin
        rxd_o = 1'b1;
        cnt = 0;
        forever begin
            get(b);
            rx_q.push_back(b);
            cnt++;
            if (burst_i) begin
                if (cnt % 3 == 2) lo = b;
                if (cnt % 3 == 0) begin
                    put(bad_echo_i ? ~lo : lo);
                    if (op_i inside {blank_test_cmd, copy_cmd, compare_image_cmd}) begin
                        put(dump(lo));
                    end
                end
            end else if (op_i == erase_cmd) begin
                if (cnt == ROUTINE_LEN + 5) put(8'h00);
            end else if (op_i != write_image_cmd && cnt % 2 == 0) begin
                put(dump(b));
            end
        end
    end
endmodule
`default_nettype wire

// *** test/write_image_cmd_seq_tb.sv ***
// self-checking bench for the programmer sequencer
`timescale 1ns/1ps
`default_nettype none
module write_image_cmd_seq_tb;
    import write_image_cmd_pkg::*;
    localparam int BD = 4;
    localparam int RL = 2;
    localparam int EW = 20;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic bad_echo = 1'b0;
    logic em_seen = 1'b0;
    logic talked = 1'b0;
    int quiet = 0;
    logic [7:0] rdata = 8'h00;
    logic rxd, txd, tgt_rst_n, erase_mode, busy, done, err, refused;
    req_s req = '0;
    mem_s mem;
    logic [7:0] umap[256];
    logic [7:0] mon[4];
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    always #25 ref_clk_i = ~ref_clk_i;
    write_image_cmd_seq #(.BAUD_DIV(16'(BD)), .ROUTINE_LEN(16'(RL)), .ERASE_WAIT_CYC(32'(EW))) write_image_cmd_seq_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .req_i(req),
        .mem_o(mem), .mem_rdata_i(rdata), .rxd_i(rxd), .txd_o(txd),
        .tgt_rst_n_o(tgt_rst_n), .erase_mode_o(erase_mode), .busy_o(busy),
        .done_o(done), .err_o(err), .refused_o(refused));
    target_model #(.BAUD_DIV(BD), .ROUTINE_LEN(RL)) target_model_i (
        .ref_clk_i(ref_clk_i), .tgt_rst_n_i(tgt_rst_n), .txd_i(txd),
        .burst_i(req.burst_variant), .op_i(req.op), .bad_echo_i(bad_echo), .rxd_o(rxd));
    // memory maps answer on the falling edge half a cycle after a read strobe
    always @(negedge ref_clk_i) begin
        if (mem.rd) rdata <= mem.monitor_space ? mon[mem.addr[1:0]] : umap[mem.addr[7:0]];
        if (mem.wr) umap[mem.addr[7:0]] <= mem.wdata;
        if (erase_mode) em_seen <= 1'b1;
        if (!tgt_rst_n) begin
            quiet <= 0;
            talked <= 1'b0;
        end else if (!txd) begin
            talked <= 1'b1;
        end else if (!talked) begin
            quiet <= quiet + 1;
        end
    end
    task automatic test_done();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_q(int i, logic [7:0] e);
        chk({8'h00, target_model_i.rx_q[i]}, {8'h00, e});
    endtask
    function automatic req_s mk(op_e op, logic burst, logic otp);
        req_s r;
        r.op = op;
        r.burst_variant = burst;
        r.otp_target = otp;
        r.start_addr = 16'h0110;
        r.end_addr = 16'h0111;
        return r;
    endfunction
    task automatic run(req_s r, logic e_err, int e_len);
        target_model_i.rx_q.delete();
        em_seen = 1'b0;
        @(negedge ref_clk_i);
        req = r;
        start_i = 1'b1;
        @(negedge ref_clk_i);
        start_i = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk({14'h0, done, err}, {14'h0, 1'b1, e_err});
        chk(16'(target_model_i.rx_q.size()), 16'(e_len));
    endtask
    task automatic t_refused();
        @(negedge ref_clk_i);
        req = mk(erase_cmd, 1'b0, 1'b1);
        start_i = 1'b1;
        @(negedge ref_clk_i);
        start_i = 1'b0;
        chk({14'h0, busy, refused}, 16'h0003);
        @(negedge ref_clk_i);
        chk({13'h0, done, busy, txd}, 16'h0005);
    endtask
    task automatic t_burst_write();
        umap[8'h10] = 8'ha5;
        umap[8'h11] = 8'h5a;
        run(mk(write_image_cmd, 1'b1, 1'b0), 1'b0, 6);
        for (int i = 0; i < 2; i++) begin
            chk_q(3 * i, 8'h01);
            chk_q(3 * i + 1, 8'h10 + 8'(i));
            chk_q(3 * i + 2, umap[8'h10 + 8'(i)]);
        end
    endtask
    task automatic t_burst_copy();
        run(mk(copy_cmd, 1'b1, 1'b0), 1'b0, 6);
        for (int i = 0; i < 2; i++) begin
            chk_q(3 * i + 2, 8'hff);
            chk({8'h00, umap[8'h10 + 8'(i)]}, {8'h00, (8'h10 + 8'(i)) ^ 8'h3c});
        end
    endtask
    task automatic t_bad_echo();
        bad_echo = 1'b1;
        run(mk(blank_test_cmd, 1'b1, 1'b0), 1'b1, 3);
        bad_echo = 1'b0;
        repeat (15 * BD) @(negedge ref_clk_i);
    endtask
    task automatic t_burst_erase();
        run(mk(erase_cmd, 1'b1, 1'b0), 1'b0, 3);
        chk({15'h0, em_seen}, 16'h0001);
        chk({15'h0, n > EW}, 16'h0001);
        chk({15'h0, quiet > EW}, 16'h0001);
        chk_q(1, 8'h10);
        chk_q(2, 8'hff);
    endtask
    task automatic t_routine(op_e op, logic [7:0] code);
        logic [7:0] e[9];
        e = '{mon[0], mon[1], 8'h01, 8'h10, 8'h01, 8'h11, code, umap[8'h10], umap[8'h11]};
        run(mk(op, 1'b0, 1'b0), 1'b0, (op == erase_cmd) ? 7 : 9);
        for (int i = 0; i < target_model_i.rx_q.size(); i++) chk_q(i, e[i]);
    endtask
    task automatic t_dump(op_e op, logic e_err);
        if (op == copy_cmd) begin
            umap[8'h10] = 8'h00;
            umap[8'h11] = 8'h00;
        end
        run(mk(op, 1'b0, 1'b0), e_err, 4);
        for (int i = 0; i < 2; i++) begin
            chk_q(2 * i, 8'h01);
            chk_q(2 * i + 1, 8'h10 + 8'(i));
            if (op == copy_cmd) begin
                chk({8'h00, umap[8'h10 + 8'(i)]}, {8'h00, 8'h2c + 8'(i)});
            end
        end
    endtask
    initial begin
        for (int i = 0; i < 256; i++) umap[i] = 8'(i);
        mon = '{8'h9c, 8'h4e, 8'h00, 8'h00};
        repeat (5) @(negedge ref_clk_i);
        chk({10'h0, txd, tgt_rst_n, busy, done, err, refused}, 16'h0020);
        chk({14'h0, erase_mode, mem.rd | mem.wr}, 16'h0000);
        rst_n_i = 1'b1;
        t_refused();
        t_burst_write();
        t_burst_copy();
        t_bad_echo();
        t_burst_erase();
        t_routine(write_image_cmd, 8'h02);
        t_routine(erase_cmd, 8'h01);
        t_dump(compare_image_cmd, 1'b0);
        t_dump(blank_test_cmd, 1'b1);
        t_dump(copy_cmd, 1'b0);
        test_done();
    end
    initial begin
        #2_000_000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
